//--- logic/cexs_fifo.sv
`timescale 1ns/1ps
module cexs_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic                       clk_i,
  input  wire logic                       srst_i,
  input  wire logic [WIDTH-1:0]           in_data_i,
  input  wire logic                       in_valid_i,
  output logic                            in_ready_o,
  output logic [WIDTH-1:0]                out_data_o,
  output logic                            out_valid_o,
  input  wire logic                       out_ready_i,
  output logic [$clog2(DEPTH+1)-1:0]      level_o
);

  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    cnt;
  logic [CW-1:0]    next_cnt;
  logic             push;
  logic             pop;

  // handshakes on both sides
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt != CW'(DEPTH));
  assign out_data_o = mem[0];
  assign level_o    = cnt;
  assign next_cnt   = CW'(cnt + CW'(push) - CW'(pop));

  // occupancy and registered not-empty flag
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      cnt         <= '0;
      out_valid_o <= 1'b0;
    end
    else
    begin
      cnt         <= next_cnt;
      out_valid_o <= (next_cnt != '0);
    end
  end

  // head always sits in entry 0, pops shift down
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      if (pop)
      begin
        if (push && (CW'(i) == CW'(cnt - 1'b1)))
          mem[i] <= in_data_i;
        else if (i < DEPTH - 1)
          mem[i] <= mem[i+1];
      end
      else if (push && (CW'(i) == cnt))
        mem[i] <= in_data_i;
    end
  end

endmodule : cexs_fifo

//--- logic/cexs_lut.sv
`timescale 1ns/1ps
module cexs_lut (
  input  wire logic                          clk_i,
  input  wire logic                          srst_i,
  input  wire logic                          wr_i,
  input  wire logic [cexs_pkg::PIX_IN_W-1:0]  waddr_i,
  input  wire logic [cexs_pkg::PIX_OUT_W-1:0] wdata_i,
  input  wire logic                          en_i,
  input  wire logic                          active_i,
  input  wire logic [cexs_pkg::PIX_IN_W-1:0]  pix_i,
  output logic      [cexs_pkg::PIX_OUT_W-1:0] pix_o
);

  localparam int ENTRIES = 1 << cexs_pkg::PIX_IN_W;

  logic [cexs_pkg::PIX_OUT_W-1:0] table_q [ENTRIES];

  // software loads entries, curves are computed off-chip
  always_ff @(posedge clk_i)
  begin
    if (wr_i)
      table_q[waddr_i] <= wdata_i; // [RULE13]
  end

  // mapped value, or the upper bits when the table is off
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pix_o <= '0;
    else if (en_i)
      pix_o <= active_i ? table_q[pix_i]
                        : pix_i[cexs_pkg::PIX_IN_W-1 -: cexs_pkg::PIX_OUT_W]; // [RULE12]
  end

endmodule : cexs_lut

//--- logic/cexs_pkg.sv
package cexs_pkg;

  // register byte offsets
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_EXPOSURE  = 8'h04;
  localparam logic [7:0] REG_RO_DELAY  = 8'h08;
  localparam logic [7:0] REG_PERIOD    = 8'h0C;
  localparam logic [7:0] REG_ROI_FIRST = 8'h10;
  localparam logic [7:0] REG_ROI_LAST  = 8'h14;
  localparam logic [7:0] REG_SW_TRIG   = 8'h18;
  localparam logic [7:0] REG_STATUS    = 8'h1C;
  localparam logic [7:0] REG_LUT_ADDR  = 8'h20;
  localparam logic [7:0] REG_LUT_DATA  = 8'h24;
  localparam logic [7:0] REG_FRAMES    = 8'h28;

  // pixel widths and sensor geometry
  localparam int          PIX_IN_W     = 12;
  localparam int          PIX_OUT_W    = 8;
  localparam int          FIFO_DEPTH   = 4;
  localparam logic [15:0] SENSOR_LINES = 16'h0400;
  localparam logic [15:0] LINE_PIXELS  = 16'h0400;
  localparam logic [15:0] HBLANK_CYC   = 16'h0010;

  // reset values
  localparam logic [31:0] EXPOSURE_RST  = 32'h0000_1000;
  localparam logic [31:0] RO_DELAY_RST  = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST    = 32'h0020_0000;
  localparam logic [15:0] ROI_FIRST_RST = 16'h0000;
  localparam logic [15:0] ROI_LAST_RST  = 16'h03FF;

  // fixed start latency of an unaligned exposure
  localparam int CLK_MHZ       = 200;
  localparam int START_LAT_NS  = 20;
  localparam int START_LAT_CYC = (START_LAT_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic {MODE_FREE, MODE_PULSE} cexs_mode_e;

  typedef enum {EX_IDLE, EX_LATENCY, EX_WAIT_LINE, EX_ACTIVE, EX_DELAY, EX_READY} cexs_ex_e;

  typedef enum {RD_IDLE, RD_CHECK, RD_LINE, RD_HBLANK} cexs_rd_e;

  // control register layout, bit 3 downward
  typedef struct packed {
    logic       run;
    logic       roi_en;
    logic       lut_en;
    cexs_mode_e mode;
  } cexs_ctrl_s;

  // status register layout, bit 31 downward
  typedef struct packed {
    logic [22:0] rsvd;
    logic [2:0]  fifo_level;
    logic        sw_pend;
    logic        rd_busy;
    logic        ex_busy;
    logic        exposing;
    logic        frame_valid;
    logic        line_valid;
  } cexs_status_s;

  // one pixel word towards the transport
  typedef struct packed {
    logic                 sof;
    logic                 eol;
    logic [PIX_OUT_W-1:0] value;
  } cexs_pix_s;

endpackage : cexs_pkg

//--- logic/cexs_sequencer.sv
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// RULE1: two modes, free-running and pulse triggered
// RULE2: free-running exposes and reads out on period
// RULE3: line_valid per line, frame_valid whole frame
// RULE4: trigger rise starts, fall ends exposure
// RULE5: every pulse sets its own exposure length
// RULE6: rise during frame waits for line_valid fall
// RULE7: rise outside frame starts after fixed latency
// RULE8: trigger falls only after frame_valid drops
// RULE9: software register write also triggers
// RULE10: programmable delay before readout starts
// RULE11: region of interest skips outside lines
// RULE12: 12-bit pixel mapped to 8-bit output
// RULE13: table holds loaded values only, no gamma
// RULE14: software trigger exposes programmed duration
module cexs_sequencer (
  input  wire logic                          CLK_I,
  input  wire logic                          SRST_I,
  input  wire logic [7:0]                    ADDR_I,
  input  wire logic [31:0]                   WDATA_I,
  input  wire logic                          WR_I,
  input  wire logic                          RD_I,
  output logic      [31:0]                   RDATA_O,
  input  wire logic                          TRIG_I,
  input  wire logic [cexs_pkg::PIX_IN_W-1:0]  SENS_PIX_I,
  output logic                               SENS_EXPOSE_O,
  output logic                               SENS_PIX_EN_O,
  output logic                               SENS_SKIP_O,
  output logic                               LINE_VALID_O,
  output logic                               FRAME_VALID_O,
  output cexs_pkg::cexs_pix_s                OUT_DATA_O,
  output logic                               OUT_VALID_O,
  input  wire logic                          OUT_READY_I
);

  cexs_pkg::cexs_ctrl_s           ctrl;
  cexs_pkg::cexs_ex_e             ex_state;
  cexs_pkg::cexs_rd_e             rd_state;
  cexs_pkg::cexs_status_s         status;
  cexs_pkg::cexs_pix_s            stage_word;
  logic [31:0]                    exposure;
  logic [31:0]                    ro_delay;
  logic [31:0]                    period;
  logic [31:0]                    per_cnt;
  logic [31:0]                    cnt;
  logic [31:0]                    frames;
  logic [15:0]                    roi_first;
  logic [15:0]                    roi_last;
  logic [15:0]                    line_cnt;
  logic [15:0]                    pix_cnt;
  logic [15:0]                    hb_cnt;
  logic [cexs_pkg::PIX_IN_W-1:0]  lut_addr;
  logic [cexs_pkg::PIX_IN_W-1:0]  pix_meta;
  logic [cexs_pkg::PIX_IN_W-1:0]  pix_sync;
  logic [cexs_pkg::PIX_OUT_W-1:0] lut_val;
  logic [2:0]                     fifo_level;
  logic                           trig_meta;
  logic                           trig_sync;
  logic                           trig_d;
  logic                           trig_rise;
  logic                           trig_fall;
  logic                           sw_pend;
  logic                           sw_take;
  logic                           hw_start;
  logic                           per_tick;
  logic                           timed;
  logic                           lv_d;
  logic                           lv_fall;
  logic                           rd_start;
  logic                           first_pix;
  logic                           in_roi;
  logic                           last_line;
  logic                           fifo_ready;
  logic                           adv;
  logic                           pix_take;
  logic                           stage_v;
  logic                           stage_sof;
  logic                           stage_eol;
  logic                           lut_wr;

  // pin inputs pass two flip-flops first
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      trig_meta <= 1'b0;
      trig_sync <= 1'b0;
      trig_d    <= 1'b0;
      pix_meta  <= '0;
      pix_sync  <= '0;
    end
    else
    begin
      trig_meta <= TRIG_I;
      trig_sync <= trig_meta;
      trig_d    <= trig_sync;
      pix_meta  <= SENS_PIX_I;
      pix_sync  <= pix_meta;
    end
  end

  // trigger edges and start requests
  assign trig_rise = trig_sync && !trig_d;
  assign trig_fall = !trig_sync && trig_d;
  assign hw_start  = ctrl.run && (ctrl.mode == cexs_pkg::MODE_PULSE) && trig_rise; // [RULE4]
  assign sw_take   = (ex_state == cexs_pkg::EX_IDLE) && ctrl.run && sw_pend && !hw_start; // [RULE9]
  assign per_tick  = ctrl.run && (ctrl.mode == cexs_pkg::MODE_FREE) && (per_cnt >= period - 32'h1); // [RULE2]
  assign lv_fall   = lv_d && !LINE_VALID_O;
  assign rd_start  = (ex_state == cexs_pkg::EX_READY) && (rd_state == cexs_pkg::RD_IDLE);
  assign lut_wr    = WR_I && (ADDR_I == cexs_pkg::REG_LUT_DATA);

  // control and timing registers
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      ctrl      <= '0;
      exposure  <= cexs_pkg::EXPOSURE_RST;
      ro_delay  <= cexs_pkg::RO_DELAY_RST;
      period    <= cexs_pkg::PERIOD_RST;
      roi_first <= cexs_pkg::ROI_FIRST_RST;
      roi_last  <= cexs_pkg::ROI_LAST_RST;
    end
    else if (WR_I)
    begin
      case (ADDR_I)
        cexs_pkg::REG_CTRL:      ctrl      <= cexs_pkg::cexs_ctrl_s'(WDATA_I[3:0]); // [RULE1]
        cexs_pkg::REG_EXPOSURE:  exposure  <= WDATA_I;
        cexs_pkg::REG_RO_DELAY:  ro_delay  <= WDATA_I;
        cexs_pkg::REG_PERIOD:    period    <= WDATA_I;
        cexs_pkg::REG_ROI_FIRST: roi_first <= WDATA_I[15:0];
        cexs_pkg::REG_ROI_LAST:  roi_last  <= WDATA_I[15:0];
        default:                 ;
      endcase
    end
  end

  // software trigger request, a new write wins over acceptance
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      sw_pend <= 1'b0;
    else if (WR_I && (ADDR_I == cexs_pkg::REG_SW_TRIG) && WDATA_I[0])
      sw_pend <= 1'b1; // [RULE9]
    else if (sw_take)
      sw_pend <= 1'b0;
  end

  // table write pointer, steps on each data write
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      lut_addr <= '0;
    else if (WR_I && (ADDR_I == cexs_pkg::REG_LUT_ADDR))
      lut_addr <= WDATA_I[cexs_pkg::PIX_IN_W-1:0];
    else if (lut_wr)
      lut_addr <= lut_addr + 1'b1;
  end

  // status word
  always_comb
  begin
    status             = '0;
    status.fifo_level  = fifo_level;
    status.sw_pend     = sw_pend;
    status.rd_busy     = (rd_state != cexs_pkg::RD_IDLE);
    status.ex_busy     = (ex_state != cexs_pkg::EX_IDLE);
    status.exposing    = SENS_EXPOSE_O;
    status.frame_valid = FRAME_VALID_O;
    status.line_valid  = LINE_VALID_O;
  end

  // read data one cycle after the strobe, zero elsewhere
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || !RD_I)
      RDATA_O <= 32'h0000_0000;
    else
    begin
      case (ADDR_I)
        cexs_pkg::REG_CTRL:      RDATA_O <= {28'h000_0000, ctrl};
        cexs_pkg::REG_EXPOSURE:  RDATA_O <= exposure;
        cexs_pkg::REG_RO_DELAY:  RDATA_O <= ro_delay;
        cexs_pkg::REG_PERIOD:    RDATA_O <= period;
        cexs_pkg::REG_ROI_FIRST: RDATA_O <= {16'h0000, roi_first};
        cexs_pkg::REG_ROI_LAST:  RDATA_O <= {16'h0000, roi_last};
        cexs_pkg::REG_STATUS:    RDATA_O <= status;
        cexs_pkg::REG_LUT_ADDR:  RDATA_O <= {20'h0_0000, lut_addr};
        cexs_pkg::REG_FRAMES:    RDATA_O <= frames;
        default:                 RDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  // free-running frame period counter
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || !ctrl.run || (ctrl.mode != cexs_pkg::MODE_FREE) || per_tick)
      per_cnt <= 32'h0000_0000;
    else
      per_cnt <= per_cnt + 32'h1; // [RULE2]
  end

  // exposure sequencer
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I || !ctrl.run)
    begin
      ex_state <= cexs_pkg::EX_IDLE;
      cnt      <= 32'h0000_0000;
      timed    <= 1'b0;
    end
    else
    begin
      case (ex_state)
        cexs_pkg::EX_IDLE:
        begin
          cnt <= 32'h0000_0000;
          if (hw_start || sw_take)
          begin
            timed    <= sw_take; // [RULE14]
            ex_state <= FRAME_VALID_O ? cexs_pkg::EX_WAIT_LINE : cexs_pkg::EX_LATENCY; // [RULE6] [RULE7]
          end
          else if (per_tick)
          begin
            timed    <= 1'b1;
            ex_state <= cexs_pkg::EX_ACTIVE; // [RULE2]
          end
        end
        cexs_pkg::EX_LATENCY:
        begin
          if (!timed && trig_fall)
            ex_state <= cexs_pkg::EX_DELAY;
          else if (cnt == 32'(cexs_pkg::START_LAT_CYC - 1))
          begin
            cnt      <= 32'h0000_0000;
            ex_state <= cexs_pkg::EX_ACTIVE; // [RULE7]
          end
          else
            cnt <= cnt + 32'h1;
        end
        cexs_pkg::EX_WAIT_LINE:
        begin
          if (!timed && trig_fall)
            ex_state <= cexs_pkg::EX_DELAY;
          else if (lv_fall || !FRAME_VALID_O) // frame over, no line edge left to wait for
            ex_state <= cexs_pkg::EX_ACTIVE; // [RULE6]
        end
        cexs_pkg::EX_ACTIVE:
        begin
          if (timed ? (cnt >= exposure - 32'h1) : trig_fall) // [RULE4] [RULE5] [RULE14]
          begin
            cnt      <= 32'h0000_0000;
            ex_state <= cexs_pkg::EX_DELAY;
          end
          else
            cnt <= cnt + 32'h1;
        end
        cexs_pkg::EX_DELAY:
        begin
          if (cnt >= ro_delay)
            ex_state <= cexs_pkg::EX_READY; // [RULE10]
          else
            cnt <= cnt + 32'h1;
        end
        cexs_pkg::EX_READY:
        begin
          if (rd_state == cexs_pkg::RD_IDLE)
            ex_state <= cexs_pkg::EX_IDLE; // [RULE8]
        end
        default: ex_state <= cexs_pkg::EX_IDLE;
      endcase
    end
  end

  // integration window towards the sensor
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
      SENS_EXPOSE_O <= 1'b0;
    else
      SENS_EXPOSE_O <= (ex_state == cexs_pkg::EX_ACTIVE);
  end

  // readout geometry and pipeline stall
  assign in_roi    = !ctrl.roi_en || ((line_cnt >= roi_first) && (line_cnt <= roi_last));
  assign last_line = (line_cnt == cexs_pkg::SENSOR_LINES - 16'h1);
  assign adv       = fifo_ready || !stage_v;
  assign pix_take  = (rd_state == cexs_pkg::RD_LINE) && adv;

  // readout sequencer with line and frame qualifiers
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      rd_state      <= cexs_pkg::RD_IDLE;
      line_cnt      <= 16'h0000;
      pix_cnt       <= 16'h0000;
      hb_cnt        <= 16'h0000;
      frames        <= 32'h0000_0000;
      LINE_VALID_O  <= 1'b0;
      FRAME_VALID_O <= 1'b0;
      SENS_SKIP_O   <= 1'b0;
      lv_d          <= 1'b0;
    end
    else
    begin
      SENS_SKIP_O <= 1'b0;
      lv_d        <= LINE_VALID_O;
      case (rd_state)
        cexs_pkg::RD_IDLE:
        begin
          if (rd_start)
          begin
            FRAME_VALID_O <= 1'b1; // [RULE3]
            line_cnt      <= 16'h0000;
            rd_state      <= cexs_pkg::RD_CHECK;
          end
        end
        cexs_pkg::RD_CHECK:
        begin
          if (in_roi)
          begin
            LINE_VALID_O <= 1'b1; // [RULE3]
            pix_cnt      <= 16'h0000;
            rd_state     <= cexs_pkg::RD_LINE;
          end
          else
          begin
            SENS_SKIP_O <= 1'b1; // [RULE11]
            if (last_line)
            begin
              FRAME_VALID_O <= 1'b0;
              frames        <= frames + 32'h1;
              rd_state      <= cexs_pkg::RD_IDLE;
            end
            else
              line_cnt <= line_cnt + 16'h1;
          end
        end
        cexs_pkg::RD_LINE:
        begin
          if (adv)
          begin
            if (pix_cnt == cexs_pkg::LINE_PIXELS - 16'h1)
            begin
              LINE_VALID_O <= 1'b0;
              hb_cnt       <= 16'h0000;
              rd_state     <= cexs_pkg::RD_HBLANK;
            end
            else
              pix_cnt <= pix_cnt + 16'h1;
          end
        end
        cexs_pkg::RD_HBLANK:
        begin
          if (hb_cnt != cexs_pkg::HBLANK_CYC - 16'h1)
            hb_cnt <= hb_cnt + 16'h1;
          else if (last_line)
          begin
            FRAME_VALID_O <= 1'b0; // [RULE3]
            frames        <= frames + 32'h1;
            rd_state      <= cexs_pkg::RD_IDLE;
          end
          else
          begin
            line_cnt <= line_cnt + 16'h1;
            rd_state <= cexs_pkg::RD_CHECK;
          end
        end
        default: rd_state <= cexs_pkg::RD_IDLE;
      endcase
    end
  end

  // table stage bookkeeping, holds while the stage is valid and the buffer is full
  always_ff @(posedge CLK_I)
  begin
    if (SRST_I)
    begin
      stage_v       <= 1'b0;
      stage_sof     <= 1'b0;
      stage_eol     <= 1'b0;
      first_pix     <= 1'b0;
      SENS_PIX_EN_O <= 1'b0;
    end
    else
    begin
      SENS_PIX_EN_O <= pix_take;
      if (rd_start)
        first_pix <= 1'b1;
      else if (pix_take)
        first_pix <= 1'b0;
      if (adv)
      begin
        stage_v   <= pix_take;
        stage_sof <= first_pix;
        stage_eol <= (pix_cnt == cexs_pkg::LINE_PIXELS - 16'h1);
      end
    end
  end

  cexs_lut u_lut (
    .clk_i    (CLK_I),
    .srst_i   (SRST_I),
    .wr_i     (lut_wr),
    .waddr_i  (lut_addr),
    .wdata_i  (WDATA_I[cexs_pkg::PIX_OUT_W-1:0]),
    .en_i     (adv),
    .active_i (ctrl.lut_en),
    .pix_i    (pix_sync),
    .pix_o    (lut_val)
  );

  assign stage_word = '{sof: stage_sof, eol: stage_eol, value: lut_val};

  cexs_fifo #(
    .WIDTH ($bits(cexs_pkg::cexs_pix_s)),
    .DEPTH (cexs_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .in_data_i   (stage_word),
    .in_valid_i  (stage_v),
    .in_ready_o  (fifo_ready),
    .out_data_o  (OUT_DATA_O),
    .out_valid_o (OUT_VALID_O),
    .out_ready_i (OUT_READY_I),
    .level_o     (fifo_level)
  );

endmodule : cexs_sequencer

//--- verification/capture_exposure_sequencer_tb.sv
`timescale 1ns/1ps
module capture_exposure_sequencer_tb;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} cexs_row_s;
  logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, st = 1'h0, mon = 1'h1, e_q = 1'h0, f_q = 1'h0;
  logic [7:0] addr = 8'h0, wid = 8'h0, expv = 8'h5A;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] pace = 2'h0;
  logic [11:0] pix = 12'hABC;
  logic trig, rdy, ex, fv, lv, ov;
  cexs_pkg::cexs_pix_s od;
  int n_mismatch = 0, checks_done = 0, npop = 0, ecnt = 0, gcnt = 0, glen = 0, e1, g1;
  cexs_row_s rows[7] = '{'{1'h0, cexs_pkg::REG_CTRL, 32'h0, 32'h0},
    '{1'h0, cexs_pkg::REG_EXPOSURE, 32'h0, cexs_pkg::EXPOSURE_RST},
    '{1'h0, cexs_pkg::REG_PERIOD, 32'h0, cexs_pkg::PERIOD_RST},
    '{1'h1, cexs_pkg::REG_PERIOD, 32'h1000, 32'h1000},
    '{1'h1, 8'h40, 32'hFFFFFFFF, 32'h0},
    '{1'h1, cexs_pkg::REG_RO_DELAY, 32'h5, 32'h5},
    '{1'h1, cexs_pkg::REG_LUT_ADDR, 32'hFABB, 32'hABB}};
  cexs_sequencer i_cexs_sequencer (.CLK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIG_I(trig), .SENS_PIX_I(pix), .SENS_EXPOSE_O(ex),
    .SENS_PIX_EN_O(), .SENS_SKIP_O(), .LINE_VALID_O(lv), .FRAME_VALID_O(fv), .OUT_DATA_O(od),
    .OUT_VALID_O(ov), .OUT_READY_I(rdy));
  cexs_partner i_cexs_partner (.clk_i(clk), .srst_i(srst), .fv_i(fv), .start_i(st), .width_i(wid),
    .pace_i(pace), .trig_o(trig), .ready_o(rdy));
  // clock
  initial
    forever #2.5 clk = ~clk;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic chk_pix(input cexs_pkg::cexs_pix_s g, input cexs_pkg::cexs_pix_s e);
    checks_done++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_pix
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 q = rdata;
  endtask : rreg
  task automatic wfv(input logic v);
    for (int i = 0; i < 9000 && fv !== v; i++) @(posedge clk);
    if (fv !== v)
      n_mismatch++;
  endtask : wfv
  task automatic wframe;
    wfv(1'h1);
    wfv(1'h0);
    repeat (12) @(posedge clk);
  endtask : wframe
  task automatic pulse(input logic [7:0] w);
    @(posedge clk);
    wid <= w;
    st <= 1'h1;
    @(posedge clk);
    st <= 1'h0;
  endtask : pulse
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  // exposure length, end-to-readout gap, popped words
  always @(posedge clk)
  begin
    e_q <= ex;
    f_q <= fv;
    ecnt <= ex ? (e_q ? ecnt + 1 : 1) : ecnt;
    gcnt <= (e_q && !ex) ? 0 : gcnt + 1;
    if (fv && !f_q)
      glen <= gcnt;
    if (mon && ov === 1'h1 && rdy)
    begin
      chk_pix(od, '{npop % 1024 == 0, npop % 1024 == 1023, expv});
      npop <= npop + 1;
    end
  end
  // hang guard
  initial
  begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    end_sim;
  end
  // main sequence
  initial
  begin
    logic [31:0] q;
    repeat (8) @(posedge clk);
    srst <= 1'h0;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, q);
      chk(q, rows[i].e);
    end
    // one-line region, table loaded at two neighbouring entries
    wreg(cexs_pkg::REG_ROI_LAST, 32'h0);
    wreg(cexs_pkg::REG_LUT_DATA, 32'h11);
    wreg(cexs_pkg::REG_LUT_DATA, 32'h5A);
    wreg(cexs_pkg::REG_CTRL, 32'hF);
    pulse(8'h14);
    wframe;
    e1 = ecnt;
    g1 = glen;
    chk(npop, 32'h400);
    // table off, longer pulse, longer delay, slow transport
    expv <= 8'hAB;
    wreg(cexs_pkg::REG_CTRL, 32'hD);
    wreg(cexs_pkg::REG_RO_DELAY, 32'hF);
    pace <= 2'h1;
    pulse(8'h28);
    wframe;
    chk(ecnt - e1, 32'h14);
    chk(glen - g1, 32'hA);
    // stalled transport, second trigger during readout
    pace <= 2'h2;
    pulse(8'h14);
    wfv(1'h1);
    pulse(8'h14);
    repeat (60) @(posedge clk);
    rreg(cexs_pkg::REG_STATUS, q);
    chk(q & 32'h1C3, 32'h103);
    pace <= 2'h0;
    wframe;
    wframe;
    chk(npop, 32'h1000);
    // software trigger, then free running
    wreg(cexs_pkg::REG_EXPOSURE, 32'h40);
    wreg(cexs_pkg::REG_SW_TRIG, 32'h1);
    wframe;
    chk(ecnt, 32'h40);
    wreg(cexs_pkg::REG_CTRL, 32'hC);
    wframe;
    wframe;
    chk(ecnt, 32'h40);
    wreg(cexs_pkg::REG_CTRL, 32'h0);
    rreg(cexs_pkg::REG_FRAMES, q);
    chk(q, 32'h7);
    chk(npop, 32'h1C00);
    // reset in mid-frame
    wreg(cexs_pkg::REG_CTRL, 32'hD);
    wreg(cexs_pkg::REG_SW_TRIG, 32'h1);
    wfv(1'h1);
    repeat (20) @(posedge clk);
    mon <= 1'h0;
    srst <= 1'h1;
    repeat (3) @(posedge clk);
    srst <= 1'h0;
    #1 chk({28'h0, fv, lv, ov, ex}, 32'h0);
    rreg(cexs_pkg::REG_CTRL, q);
    chk(q, 32'h0);
    end_sim;
  end
endmodule : capture_exposure_sequencer_tb

//--- verification/cexs_partner.sv
`timescale 1ns/1ps
module cexs_partner (
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       fv_i,
  input  wire logic       start_i,
  input  wire logic [7:0] width_i,
  input  wire logic [1:0] pace_i,
  output logic            trig_o,
  output logic            ready_o
);
  logic [7:0] cnt;
  logic       tog;
  // trigger pulse: rise on start, hold width, fall once frame_valid is low
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      trig_o <= 1'h0;
      cnt    <= 8'h0;
    end
    else if (start_i && !trig_o)
    begin
      trig_o <= 1'h1;
      cnt    <= width_i;
    end
    else if (cnt != 8'h0)
      cnt <= cnt - 8'h1;
    else if (!fv_i)
      trig_o <= 1'h0;
  end
  // transport pace: 0 prompt, 1 half rate, 2 stalled
  always_ff @(posedge clk_i)
    tog <= srst_i ? 1'h0 : !tog;
  assign ready_o = (pace_i == 2'h0) || (pace_i == 2'h1 && tog);
endmodule : cexs_partner

//--- verification/cexs_sequencer_props.sv
`timescale 1ns/1ps
module cexs_sequencer_props (
  input wire logic                CLK_I,
  input wire logic                SRST_I,
  input wire logic                RD_I,
  input wire logic [31:0]         RDATA_O,
  input wire logic                SENS_EXPOSE_O,
  input wire logic                SENS_PIX_EN_O,
  input wire logic                SENS_SKIP_O,
  input wire logic                LINE_VALID_O,
  input wire logic                FRAME_VALID_O,
  input wire cexs_pkg::cexs_pix_s OUT_DATA_O,
  input wire logic                OUT_VALID_O,
  input wire logic                OUT_READY_I
);
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (SRST_I);
  // read data only in the slot after a strobe
  a_rd_slot: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("stray read data");
  // line and frame qualifiers
  a_lv_frame: assert property (LINE_VALID_O |-> FRAME_VALID_O)
    else $error("line valid outside frame");
  a_fv_span: assert property ($rose(FRAME_VALID_O) |=> FRAME_VALID_O [*8])
    else $error("frame valid too short");
  a_skip_gap: assert property (SENS_SKIP_O |-> $past(FRAME_VALID_O) && !$past(LINE_VALID_O))
    else $error("skip pulse misplaced");
  a_pix_line: assert property (SENS_PIX_EN_O |-> LINE_VALID_O || $past(LINE_VALID_O))
    else $error("pixel taken outside line");
  // stream word held while stalled
  a_out_hold: assert property (OUT_VALID_O && !OUT_READY_I |=> OUT_VALID_O && $stable(OUT_DATA_O))
    else $error("stream word dropped");
  // exposure timing against readout
  a_ovl_align: assert property ($rose(SENS_EXPOSE_O) && $past(FRAME_VALID_O, 2)
    |-> $past(LINE_VALID_O, 3) && !$past(LINE_VALID_O, 2))
    else $error("overlap start not on line end");
  a_quiet_rise: assert property ($rose(FRAME_VALID_O) |-> !SENS_EXPOSE_O)
    else $error("readout during exposure");
endmodule : cexs_sequencer_props
bind cexs_sequencer cexs_sequencer_props i_cexs_sequencer_props (.CLK_I(CLK_I), .SRST_I(SRST_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .SENS_EXPOSE_O(SENS_EXPOSE_O), .SENS_PIX_EN_O(SENS_PIX_EN_O),
  .SENS_SKIP_O(SENS_SKIP_O), .LINE_VALID_O(LINE_VALID_O), .FRAME_VALID_O(FRAME_VALID_O),
  .OUT_DATA_O(OUT_DATA_O), .OUT_VALID_O(OUT_VALID_O), .OUT_READY_I(OUT_READY_I));
